// File: verilog/sysctl_pkg.sv
// shared constants and types for the system-control flag checks
package sysctl_pkg;

  // feature control bit positions
  localparam int BIT_V86_EXT = 0;
  localparam int BIT_PROT_VIRT_INT = 1;
  localparam int BIT_LARGE_PAGE = 4;
  localparam int BIT_PHYS_ADDR_EXT = 5;
  localparam int BIT_MCHECK = 6;
  localparam int BIT_GLOBAL_PAGE = 7;
  localparam int BIT_PERF_USER = 8;
  localparam int BIT_FX_SUPPORT = 9;
  localparam int BIT_SIMD_EXC = 10;
  localparam int BIT_EXT_STATE = 18;
  localparam logic [63:0] FC_WRITABLE = 64'h0000_0000_0004_07ff;
  localparam logic [63:0] FC_RESET = 64'h0000_0000_0000_0000;

  // flags bit positions
  localparam int FL_SINGLE_STEP = 8;
  localparam int FL_INT_ENABLE = 9;
  localparam int FL_IO_PRIVILEGE_FIELD_LO = 12;
  localparam int FL_IO_PRIVILEGE_FIELD_HI = 13;
  localparam int FL_VIRT_INT = 19;
  localparam int FL_VIRT_PEND = 20;
  localparam logic [63:0] FL_STATUS_MASK = 64'h0000_0000_0000_08d5;
  localparam logic [63:0] FL_USER_MASK = 64'h0000_0000_0000_0cd5;
  localparam logic [63:0] FL_RESET = 64'h0000_0000_0000_0002;
  localparam logic [63:0] FL_FIXED_ONE = 64'h0000_0000_0000_0002;

  // control register indices
  localparam logic [3:0] CR_IDX_PT_BASE = 4'h3;
  localparam logic [3:0] CR_IDX_FEATURE = 4'h4;
  localparam logic [3:0] CR_IDX_TASK_PRI = 4'h8;
  localparam logic [15:0] CR_IMPL_MASK = 16'h011d;

  // extended state control
  localparam int EXT_CONTROL_REG0_X87_BIT = 0;
  localparam logic [63:0] EXT_CONTROL_REG0_RESET = 64'h0000_0000_0000_0001;

  localparam logic [1:0] PRIV_KERNEL = 2'h0;
  localparam logic [1:0] PRIV_USER = 2'h3;

  typedef enum logic [3:0] {
    op_none, op_cr_read, op_cr_write, op_flags_read, op_flags_write,
    op_io, op_perf_read, op_media, op_fx_save, op_ext_get, op_ext_set,
    op_int_set, op_int_clear
  } op_type;

  typedef enum logic [1:0] {
    fault_none, fault_ud, fault_gp, fault_xf
  } fault_type;

  typedef enum logic [1:0] {pg_4k, pg_2m, pg_4m} page_size_type;

  typedef enum logic [1:0] {if_real, if_virtual, if_denied} if_mode_type;

endpackage : sysctl_pkg

// File: verilog/check_if.sv
// request and verdict signals shared by the top and its checkers
`timescale 1ns/1ps
interface check_if;
  import sysctl_pkg::*;
  op_type op;
  logic [3:0] cr_idx;
  logic [1:0] current_priv_level;
  logic [1:0] io_privilege_field;
  logic [63:0] feat;
  logic simd_unmasked;
  fault_type cr_fault;
  fault_type priv_fault;
  if_mode_type if_mode;

  modport owner (output op, cr_idx, current_priv_level, io_privilege_field, feat, simd_unmasked,
                 input cr_fault, priv_fault, if_mode);
  modport cr_side (input op, cr_idx, current_priv_level, feat, output cr_fault);
  modport priv_side (input op, current_priv_level, io_privilege_field, feat, simd_unmasked,
                     output priv_fault, if_mode);
endinterface : check_if

// File: verilog/cr_access_check.sv
// control-register and extended-state access checks
`timescale 1ns/1ps
module cr_access_check
  import sysctl_pkg::*;
(
  check_if.cr_side chk
);

  always_comb begin
    chk.cr_fault = fault_none;
    unique case (chk.op)
      op_cr_read, op_cr_write: begin
        if (!CR_IMPL_MASK[chk.cr_idx]) begin
          chk.cr_fault = fault_ud;
        end else if (chk.current_priv_level != PRIV_KERNEL) begin
          chk.cr_fault = fault_gp;
        end
      end
      op_ext_get, op_ext_set: begin
        if (!chk.feat[BIT_EXT_STATE]) begin
          chk.cr_fault = fault_ud;
        end else if (chk.op == op_ext_set && chk.current_priv_level != PRIV_KERNEL) begin
          chk.cr_fault = fault_gp;
        end
      end
      default: chk.cr_fault = fault_none;
    endcase
  end

endmodule : cr_access_check

// File: verilog/priv_check.sv
// privilege and feature-enable checks for instruction classes
`timescale 1ns/1ps
module priv_check
  import sysctl_pkg::*;
(
  check_if.priv_side chk
);

  always_comb begin
    // interrupt flag ownership from privilege, io level and virtual modes
    if (chk.current_priv_level <= chk.io_privilege_field) begin
      chk.if_mode = if_real;
    end else if ((chk.feat[BIT_V86_EXT] || chk.feat[BIT_PROT_VIRT_INT])
                 && chk.current_priv_level == PRIV_USER) begin
      chk.if_mode = if_virtual;
    end else begin
      chk.if_mode = if_denied;
    end
  end

  always_comb begin
    chk.priv_fault = fault_none;
    unique case (chk.op)
      op_io: begin
        if (chk.current_priv_level > chk.io_privilege_field) chk.priv_fault = fault_gp;
      end
      op_perf_read: begin
        if (!chk.feat[BIT_PERF_USER] && chk.current_priv_level != PRIV_KERNEL) begin
          chk.priv_fault = fault_gp;
        end
      end
      op_media: begin
        if (!chk.feat[BIT_FX_SUPPORT]) begin
          chk.priv_fault = fault_ud;
        end else if (chk.simd_unmasked) begin
          chk.priv_fault = chk.feat[BIT_SIMD_EXC] ? fault_xf : fault_ud;
        end
      end
      op_int_set, op_int_clear: begin
        if (chk.if_mode == if_denied) chk.priv_fault = fault_gp;
      end
      default: chk.priv_fault = fault_none;
    endcase
  end

endmodule : priv_check

// File: verilog/system_control_flag_checks.sv
// feature control, flags and exception checks for the execution pipeline
//
// Overview of operation
// - physical address extension selects wide table entries, 52-bit addresses
// - with extension on, page size is 4K or 2M from the directory size bit
// - long mode is allowed only while physical address extension is set
// - machine check enable gates the abort for uncorrectable errors
// - enabled errors are logged always; correctable ones never abort
// - page base writes flush the TLB, keeping global entries when enabled
// - perf counter read is kernel-only unless the user enable is set
// - wide media instructions fault invalid-opcode without fx state support
// - unmasked media fp error gives simd fault or invalid-opcode per enable
// - extended state get/set work only with extended state support enabled
// - reserved control register accesses fault invalid-opcode
// - in 64-bit mode the extension prefix bit reaches registers 8 to 15
// - control register 8 is the task priority register
// - legacy flags view is the low 32 bits of the flags register
// - status bits are updated by hardware and readable at any level
// - single step raises one debug trap after the next completed instruction
// - single step clears whenever any exception or interrupt is taken
// - interrupt enable clear ignores maskable interrupts only
// - interrupt enable changes depend on privilege, io level, virtual modes
// - io instructions need privilege at most the io level, else protection
// - large page enable is ignored while address extension is set
// - virtual modes enable the virtual interrupt and pending flag bits
`timescale 1ns/1ps
module system_control_flag_checks
  import sysctl_pkg::*;
#(
  parameter int TPR_BITS = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // instruction request from the pipeline
  input wire logic req_valid,
  input wire op_type req_op,
  input wire logic [2:0] req_modrm_reg,
  input wire logic req_reg_ext,
  input wire logic req_mode64,
  input wire logic [1:0] req_cpl,
  input wire logic [63:0] req_wdata,
  input wire logic req_simd_unmasked,
  // arithmetic status update
  input wire logic status_we,
  input wire logic [63:0] status_value,
  // error and interrupt events
  input wire logic mc_err_valid,
  input wire logic mc_err_uncorr,
  input wire logic mc_err_bank_en,
  input wire logic nmi_req,
  input wire logic maskable_req,
  input wire logic ext_exc_taken,
  // translation hooks
  input wire logic walk_valid,
  input wire logic walk_pde_ps,
  input wire logic long_mode_req,
  // instruction response
  output logic resp_valid,
  output fault_type resp_fault,
  output logic [63:0] resp_rdata,
  // raised events
  output logic debug_trap,
  output logic machine_check_abort,
  output logic mc_log,
  output logic nmi_take,
  output logic int_take,
  // TLB control
  output logic tlb_flush,
  output logic tlb_keep_global,
  // register views
  output logic [63:0] feature_control,
  output logic [63:0] flags,
  output logic [31:0] legacy_flags,
  output logic [63:0] ext_control0,
  output logic [TPR_BITS-1:0] task_priority,
  output logic [63:0] page_table_base,
  // translation results
  output logic pte_wide,
  output page_size_type page_size,
  output logic long_mode_ok
);

  if (TPR_BITS < 1 || TPR_BITS > 8) begin : g_bad_tpr
    $error("TPR_BITS must lie between 1 and 8");
  end

  typedef struct packed {
    logic [63:0] fc;
    logic [63:0] fl;
    logic [63:0] ext_control_reg0;
    logic [63:0] cr3;
    logic [TPR_BITS-1:0] task_priority_reg;
    logic resp_valid;
    fault_type resp_fault;
    logic [63:0] resp_rdata;
    logic debug_trap;
    logic mc_abort;
    logic mc_log;
    logic nmi_take;
    logic int_take;
    logic tlb_flush;
    logic tlb_keep;
    logic pte_wide;
    page_size_type page_size;
    logic long_ok;
  } state_type;

  state_type state_q;
  state_type state_d;

  check_if chk ();

  logic [3:0] cr_idx;
  logic [1:0] io_privilege_field;
  fault_type base_fault;
  fault_type fault;
  logic done;
  logic exc_taken;
  logic virt_en;

  // control register 8 and above only exist behind the extension prefix
  assign cr_idx = {req_reg_ext & req_mode64, req_modrm_reg};
  assign io_privilege_field = state_q.fl[FL_IO_PRIVILEGE_FIELD_HI:FL_IO_PRIVILEGE_FIELD_LO];
  assign virt_en = state_q.fc[BIT_V86_EXT] | state_q.fc[BIT_PROT_VIRT_INT];

  // checkers see only registered control state, so a write reaches the
  // next instruction and never the one that made it
  assign chk.op = req_valid ? req_op : op_none;
  assign chk.cr_idx = cr_idx;
  assign chk.current_priv_level = req_cpl;
  assign chk.io_privilege_field = io_privilege_field;
  assign chk.feat = state_q.fc;
  assign chk.simd_unmasked = req_simd_unmasked;

  cr_access_check u_cr_check (
    .chk(chk.cr_side)
  );

  priv_check u_priv_check (
    .chk(chk.priv_side)
  );

  always_comb begin
    base_fault = (chk.cr_fault != fault_none) ? chk.cr_fault
                                              : chk.priv_fault;
    fault = base_fault;
    if (req_valid && base_fault == fault_none) begin
      unique case (req_op)
        op_cr_write: begin
          if (cr_idx == CR_IDX_FEATURE && (req_wdata & ~FC_WRITABLE) != '0)
            fault = fault_gp;
          if (cr_idx == CR_IDX_TASK_PRI && (req_wdata >> TPR_BITS) != '0)
            fault = fault_gp;
        end
        op_ext_set: begin
          if (!req_wdata[EXT_CONTROL_REG0_X87_BIT]) fault = fault_gp;
        end
        op_int_set: begin
          // enabling virtual interrupts with one pending hands it to the os
          if (chk.if_mode == if_virtual && state_q.fl[FL_VIRT_PEND])
            fault = fault_gp;
        end
        default: fault = base_fault;
      endcase
    end
  end

  assign done = req_valid && fault == fault_none;

  always_comb begin
    state_d = state_q;
    state_d.resp_valid = req_valid;
    state_d.resp_fault = req_valid ? fault : fault_none;
    state_d.resp_rdata = '0;
    state_d.tlb_flush = 1'b0;
    state_d.tlb_keep = 1'b0;

    // hardware status update comes first; an explicit flags write wins
    if (status_we) begin
      state_d.fl = (state_q.fl & ~FL_STATUS_MASK)
                 | (status_value & FL_STATUS_MASK);
    end

    if (done) begin
      unique case (req_op)
        op_cr_read: begin
          if (cr_idx == CR_IDX_FEATURE) state_d.resp_rdata = state_q.fc;
          if (cr_idx == CR_IDX_PT_BASE) state_d.resp_rdata = state_q.cr3;
          if (cr_idx == CR_IDX_TASK_PRI) begin
            state_d.resp_rdata = {{(64-TPR_BITS){1'b0}}, state_q.task_priority_reg};
          end
        end
        op_cr_write: begin
          if (cr_idx == CR_IDX_FEATURE) state_d.fc = req_wdata;
          if (cr_idx == CR_IDX_TASK_PRI) begin
            state_d.task_priority_reg = req_wdata[TPR_BITS-1:0];
          end
          if (cr_idx == CR_IDX_PT_BASE) begin
            state_d.cr3 = req_wdata;
            state_d.tlb_flush = 1'b1;
            state_d.tlb_keep = state_q.fc[BIT_GLOBAL_PAGE];
          end
        end
        op_flags_read: state_d.resp_rdata = state_q.fl;
        op_flags_write: begin
          state_d.fl = (state_d.fl & ~FL_USER_MASK)
                     | (req_wdata & FL_USER_MASK);
          state_d.fl[FL_SINGLE_STEP] = req_wdata[FL_SINGLE_STEP];
          if (chk.if_mode == if_real) begin
            state_d.fl[FL_INT_ENABLE] = req_wdata[FL_INT_ENABLE];
          end
          if (req_cpl == PRIV_KERNEL) begin
            state_d.fl[FL_IO_PRIVILEGE_FIELD_HI:FL_IO_PRIVILEGE_FIELD_LO] =
              req_wdata[FL_IO_PRIVILEGE_FIELD_HI:FL_IO_PRIVILEGE_FIELD_LO];
            state_d.fl[FL_VIRT_INT] = virt_en & req_wdata[FL_VIRT_INT];
            state_d.fl[FL_VIRT_PEND] = virt_en & req_wdata[FL_VIRT_PEND];
          end
        end
        op_int_set, op_int_clear: begin
          if (chk.if_mode == if_virtual) begin
            state_d.fl[FL_VIRT_INT] = (req_op == op_int_set);
          end else begin
            state_d.fl[FL_INT_ENABLE] = (req_op == op_int_set);
          end
        end
        op_ext_get: state_d.resp_rdata = state_q.ext_control_reg0;
        op_ext_set: state_d.ext_control_reg0 = req_wdata;
        default: state_d.resp_rdata = '0;
      endcase
    end
    state_d.fl = state_d.fl | FL_FIXED_ONE;

    // machine check: log regardless of enable, abort only when enabled
    state_d.mc_log = mc_err_valid & mc_err_bank_en;
    state_d.mc_abort = mc_err_valid & mc_err_uncorr
                     & state_q.fc[BIT_MCHECK];

    // nmi is never masked; maskable ones follow the enable flag
    state_d.nmi_take = nmi_req;
    state_d.int_take = maskable_req & ~nmi_req
                     & state_q.fl[FL_INT_ENABLE];

    // the flag as seen before this instruction decides the trap, so the
    // instruction that sets it is not itself stepped
    state_d.debug_trap = done & state_q.fl[FL_SINGLE_STEP];

    exc_taken = state_d.debug_trap | state_d.mc_abort | state_d.nmi_take
              | state_d.int_take | ext_exc_taken
              | (req_valid & fault != fault_none);
    if (exc_taken) state_d.fl[FL_SINGLE_STEP] = 1'b0;

    // translation controls
    state_d.pte_wide = state_q.fc[BIT_PHYS_ADDR_EXT];
    state_d.long_ok = long_mode_req & state_q.fc[BIT_PHYS_ADDR_EXT];
    if (walk_valid) begin
      if (state_q.fc[BIT_PHYS_ADDR_EXT]) begin
        // large page enable has no say here
        state_d.page_size = walk_pde_ps ? pg_2m : pg_4k;
      end else if (state_q.fc[BIT_LARGE_PAGE] && walk_pde_ps) begin
        state_d.page_size = pg_4m;
      end else begin
        state_d.page_size = pg_4k;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= '{fc: FC_RESET, fl: FL_RESET, ext_control_reg0: EXT_CONTROL_REG0_RESET,
                   resp_fault: fault_none, page_size: pg_4k, default: '0};
    end else begin
      state_q <= state_d;
    end
  end

  assign resp_valid = state_q.resp_valid;
  assign resp_fault = state_q.resp_fault;
  assign resp_rdata = state_q.resp_rdata;
  assign debug_trap = state_q.debug_trap;
  assign machine_check_abort = state_q.mc_abort;
  assign mc_log = state_q.mc_log;
  assign nmi_take = state_q.nmi_take;
  assign int_take = state_q.int_take;
  assign tlb_flush = state_q.tlb_flush;
  assign tlb_keep_global = state_q.tlb_keep;
  assign feature_control = state_q.fc;
  assign flags = state_q.fl;
  assign legacy_flags = state_q.fl[31:0];
  assign ext_control0 = state_q.ext_control_reg0;
  assign task_priority = state_q.task_priority_reg;
  assign page_table_base = state_q.cr3;
  assign pte_wide = state_q.pte_wide;
  assign page_size = state_q.page_size;
  assign long_mode_ok = state_q.long_ok;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_media_needs_fx: assert property (
    req_valid && req_op == op_media && !feature_control[BIT_FX_SUPPORT]
    |=> resp_valid && resp_fault == fault_ud)
    else $error("media op without fx support did not fault");

  a_cr_reserved_ud: assert property (
    req_valid && (req_op == op_cr_read || req_op == op_cr_write)
    && !CR_IMPL_MASK[cr_idx] |=> resp_fault == fault_ud && resp_rdata == '0)
    else $error("reserved control register access not refused");

  a_mc_gate: assert property (
    mc_err_valid && mc_err_uncorr
    |=> machine_check_abort == $past(feature_control[BIT_MCHECK]))
    else $error("machine check abort does not follow its enable");

  a_mc_correctable: assert property (
    mc_err_valid && !mc_err_uncorr && mc_err_bank_en
    |=> mc_log && !machine_check_abort)
    else $error("correctable error aborted or was not logged");

  a_io_priv_gp: assert property (
    req_valid && req_op == op_io
    |=> resp_fault == (($past(req_cpl) > $past(flags[FL_IO_PRIVILEGE_FIELD_HI:FL_IO_PRIVILEGE_FIELD_LO]))
                       ? fault_gp : fault_none))
    else $error("io privilege check wrong");

  a_step_trap: assert property (
    done && flags[FL_SINGLE_STEP] |=> debug_trap ##0 !flags[FL_SINGLE_STEP])
    else $error("single step trap missing or flag not cleared");

  a_step_clear: assert property (
    (nmi_take || int_take || machine_check_abort
     || (resp_valid && resp_fault != fault_none)) |-> !flags[FL_SINGLE_STEP])
    else $error("single step survived an exception");

  a_int_masked: assert property (
    maskable_req && !nmi_req && !flags[FL_INT_ENABLE] |=> !int_take)
    else $error("maskable interrupt taken while disabled");

  a_tlb_global: assert property (
    done && req_op == op_cr_write && cr_idx == CR_IDX_PT_BASE
    |=> tlb_flush && tlb_keep_global == $past(feature_control[BIT_GLOBAL_PAGE])
        ##1 !tlb_flush)
    else $error("page base write flush wrong");

  a_perf_user: assert property (
    req_valid && req_op == op_perf_read && req_cpl != PRIV_KERNEL
    && !feature_control[BIT_PERF_USER] |=> resp_fault == fault_gp)
    else $error("user perf counter read not refused");

  a_long_needs_ext: assert property (
    long_mode_ok |-> $past(feature_control[BIT_PHYS_ADDR_EXT]))
    else $error("long mode allowed without address extension");

endmodule : system_control_flag_checks

// File: sim/pipe_model.sv
// execution pipeline model that issues one instruction at a time
`timescale 1ns/1ps
module pipe_model
  import sysctl_pkg::*;
(
  // clock
  input wire logic clk,
  // instruction request
  output logic req_valid,
  output op_type req_op,
  output logic [2:0] req_modrm_reg,
  output logic req_reg_ext,
  output logic req_mode64,
  output logic [1:0] req_cpl,
  output logic [63:0] req_wdata,
  output logic req_simd_unmasked,
  // instruction response
  input wire logic resp_valid,
  input wire fault_type resp_fault,
  input wire logic [63:0] resp_rdata
);
  initial begin
    req_valid = 1'b0;
    req_op = op_none;
    req_modrm_reg = 3'h0;
    req_reg_ext = 1'b0;
    req_mode64 = 1'b0;
    req_cpl = 2'h0;
    req_wdata = 64'h0;
    req_simd_unmasked = 1'b0;
  end

  task automatic issue(input op_type op, input logic [3:0] cr,
      input logic m64, input logic [1:0] current_priv_level, input logic [63:0] wd,
      input logic sm, output fault_type f, output logic [63:0] rd,
      output logic ok);
    @(posedge clk);
    #1;
    req_valid = 1'b1;
    req_op = op;
    req_reg_ext = cr[3];
    req_modrm_reg = cr[2:0];
    req_mode64 = m64;
    req_cpl = current_priv_level;
    req_wdata = wd;
    req_simd_unmasked = sm;
    @(posedge clk);
    #1;
    ok = resp_valid;
    f = resp_fault;
    rd = resp_rdata;
    req_valid = 1'b0;
    // idle data and register lines flip so a stale value never passes for a live one
    req_wdata = ~req_wdata;
    req_modrm_reg = ~req_modrm_reg;
  endtask : issue
endmodule : pipe_model

// File: sim/testbench.sv
// self-checking bench for the system-control flag checks
`timescale 1ns/1ps
module testbench;
  import sysctl_pkg::*;
  typedef struct {
    op_type op; logic [3:0] cr; logic m64; logic [1:0] current_priv_level;
    logic [63:0] wd; logic sm; fault_type f; logic [63:0] rd;
  } row_type;
  logic clk = 1'b0, rstn = 1'b0;
  logic req_valid, req_reg_ext, req_mode64, req_simd_unmasked;
  op_type req_op;
  logic [2:0] req_modrm_reg;
  logic [1:0] req_cpl;
  logic [63:0] req_wdata, status_value = 64'h0;
  logic status_we = 1'b0, mc_err_valid = 1'b0, mc_err_uncorr = 1'b0;
  logic mc_err_bank_en = 1'b0, nmi_req = 1'b0, maskable_req = 1'b0;
  logic ext_exc_taken = 1'b0, walk_valid = 1'b0, walk_pde_ps = 1'b0;
  logic long_mode_req = 1'b0;
  logic resp_valid, debug_trap, machine_check_abort, mc_log, nmi_take;
  logic int_take, tlb_flush, tlb_keep_global, pte_wide, long_mode_ok;
  fault_type resp_fault;
  logic [63:0] resp_rdata, feature_control, flags, ext_control0;
  logic [63:0] page_table_base;
  logic [31:0] legacy_flags;
  logic [3:0] task_priority;
  page_size_type page_size;
  int failures = 0, comparisons = 0;
  row_type rows [20];

  always #12.5 clk = ~clk;

  system_control_flag_checks #(.TPR_BITS(4)) dut (
    .clk(clk), .rstn(rstn), .req_valid(req_valid), .req_op(req_op),
    .req_modrm_reg(req_modrm_reg), .req_reg_ext(req_reg_ext),
    .req_mode64(req_mode64), .req_cpl(req_cpl), .req_wdata(req_wdata),
    .req_simd_unmasked(req_simd_unmasked), .status_we(status_we),
    .status_value(status_value), .mc_err_valid(mc_err_valid),
    .mc_err_uncorr(mc_err_uncorr), .mc_err_bank_en(mc_err_bank_en),
    .nmi_req(nmi_req), .maskable_req(maskable_req),
    .ext_exc_taken(ext_exc_taken), .walk_valid(walk_valid),
    .walk_pde_ps(walk_pde_ps), .long_mode_req(long_mode_req),
    .resp_valid(resp_valid), .resp_fault(resp_fault),
    .resp_rdata(resp_rdata), .debug_trap(debug_trap),
    .machine_check_abort(machine_check_abort), .mc_log(mc_log),
    .nmi_take(nmi_take), .int_take(int_take), .tlb_flush(tlb_flush),
    .tlb_keep_global(tlb_keep_global), .feature_control(feature_control),
    .flags(flags), .legacy_flags(legacy_flags),
    .ext_control0(ext_control0), .task_priority(task_priority),
    .page_table_base(page_table_base), .pte_wide(pte_wide),
    .page_size(page_size), .long_mode_ok(long_mode_ok));

  pipe_model pipe (
    .clk(clk), .req_valid(req_valid), .req_op(req_op),
    .req_modrm_reg(req_modrm_reg), .req_reg_ext(req_reg_ext),
    .req_mode64(req_mode64), .req_cpl(req_cpl), .req_wdata(req_wdata),
    .req_simd_unmasked(req_simd_unmasked), .resp_valid(resp_valid),
    .resp_fault(resp_fault), .resp_rdata(resp_rdata));

  task automatic check(input logic good, input string msg);
    comparisons++;
    if (good !== 1'b1) begin
      failures++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic done(input string name);
    $display("test %s done", name);
  endtask : done

  // one event cycle: {mc valid, uncorrectable, bank enable, nmi, maskable}
  task automatic ev(input logic [4:0] v);
    @(posedge clk);
    #1;
    {mc_err_valid, mc_err_uncorr, mc_err_bank_en, nmi_req, maskable_req} = v;
    @(posedge clk);
    #1;
    {mc_err_valid, mc_err_uncorr, mc_err_bank_en, nmi_req, maskable_req} = 0;
  endtask : ev

  task automatic final_report();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report

  initial begin
    // the whole run is little more than a hundred cycles
    #100000;
    failures++;
    final_report();
  end

  initial begin
    fault_type f;
    logic [63:0] rd;
    logic ok;
    rows[0] = '{op_media, 4'h0, 1'b0, 2'h0, 64'h0, 1'b0, fault_ud, 64'h0};
    rows[1] = '{op_fx_save, 4'h0, 1'b0, 2'h0, 64'h0, 1'b0, fault_none, 64'h0};
    rows[2] = '{op_perf_read, 4'h0, 1'b0, 2'h3, 64'h0, 1'b0, fault_gp, 64'h0};
    rows[3] = '{op_perf_read, 4'h0, 1'b0, 2'h0, 64'h0, 1'b0, fault_none, 0};
    rows[4] = '{op_ext_get, 4'h0, 1'b0, 2'h0, 64'h0, 1'b0, fault_ud, 64'h0};
    rows[5] = '{op_io, 4'h0, 1'b0, 2'h3, 64'h0, 1'b0, fault_gp, 64'h0};
    rows[6] = '{op_io, 4'h0, 1'b0, 2'h0, 64'h0, 1'b0, fault_none, 64'h0};
    rows[7] = '{op_int_set, 4'h0, 1'b0, 2'h3, 64'h0, 1'b0, fault_gp, 64'h0};
    rows[8] = '{op_cr_write, 4'h4, 1'b0, 2'h0, 64'h407f0, 1'b0, fault_none, 0};
    rows[9] = '{op_perf_read, 4'h0, 1'b0, 2'h3, 64'h0, 1'b0, fault_none, 0};
    rows[10] = '{op_media, 4'h0, 1'b0, 2'h0, 64'h0, 1'b1, fault_xf, 64'h0};
    rows[11] = '{op_media, 4'h0, 1'b0, 2'h0, 64'h0, 1'b0, fault_none, 0};
    rows[12] = '{op_ext_get, 4'h0, 1'b0, 2'h3, 64'h0, 1'b0, fault_none, 1};
    rows[13] = '{op_cr_read, 4'h4, 1'b0, 2'h0, 0, 1'b0, fault_none, 64'h407f0};
    rows[14] = '{op_cr_write, 4'h4, 1'b0, 2'h0, 64'h2f0, 1'b0, fault_none, 0};
    rows[15] = '{op_media, 4'h0, 1'b0, 2'h0, 64'h0, 1'b1, fault_ud, 64'h0};
    rows[16] = '{op_cr_write, 4'h8, 1'b1, 2'h0, 64'h5, 1'b0, fault_none, 0};
    rows[17] = '{op_cr_read, 4'h8, 1'b1, 2'h0, 64'h0, 1'b0, fault_none, 5};
    rows[18] = '{op_cr_read, 4'h8, 1'b0, 2'h0, 64'h0, 1'b0, fault_none, 0};
    rows[19] = '{op_cr_write, 4'h4, 1'b0, 2'h0, 64'h800, 1'b0, fault_gp, 0};
    repeat (12) @(posedge clk);
    #1;
    rstn = 1'b1;
    for (int i = 0; i < 20; i++) begin
      pipe.issue(rows[i].op, rows[i].cr, rows[i].m64, rows[i].current_priv_level,
                 rows[i].wd, rows[i].sm, f, rd, ok);
      check(ok === 1'b1 && f === rows[i].f && rd === rows[i].rd,
            $sformatf("row %0d", i));
    end
    done("table");
    for (int i = 1; i < 16; i++) begin
      if (!(i inside {2, 3, 4, 8})) begin
        pipe.issue(op_cr_read, 4'(i), 1'b1, 2'h0, 64'h0, 1'b0, f, rd, ok);
        check(ok === 1'b1 && f === fault_ud && rd === 0, "reserved cr");
      end
    end
    done("reserved");
    ev(5'b11100);
    check(machine_check_abort === 1'b1 && mc_log === 1'b1, "mc on");
    ev(5'b10100);
    check(machine_check_abort === 1'b0 && mc_log === 1'b1, "mc corr");
    done("machine check");
    pipe.issue(op_cr_write, 4'h3, 1'b0, 2'h0, 64'h1000, 1'b0, f, rd, ok);
    check(tlb_flush === 1'b1 && tlb_keep_global === 1'b1, "tlb");
    check(page_table_base === 64'h1000, "base");
    @(posedge clk);
    #1;
    {walk_valid, walk_pde_ps, long_mode_req} = 3'b111;
    @(posedge clk);
    #1;
    walk_valid = 1'b0;
    check(page_size === pg_2m && pte_wide === 1'b1, "wide 2m");
    check(long_mode_ok === 1'b1, "long mode");
    done("translation");
    pipe.issue(op_flags_write, 4'h0, 1'b0, 2'h0, 64'h102, 1'b0, f, rd, ok);
    check(debug_trap === 1'b0 && flags[8] === 1'b1, "step set");
    pipe.issue(op_none, 4'h0, 1'b0, 2'h0, 64'h0, 1'b0, f, rd, ok);
    check(debug_trap === 1'b1 && flags[8] === 1'b0, "step trap");
    pipe.issue(op_flags_write, 4'h0, 1'b0, 2'h0, 64'h102, 1'b0, f, rd, ok);
    @(posedge clk);
    #1;
    ext_exc_taken = 1'b1;
    @(posedge clk);
    #1;
    ext_exc_taken = 1'b0;
    check(flags[8] === 1'b0, "step cleared by exception");
    pipe.issue(op_none, 4'h0, 1'b0, 2'h0, 64'h0, 1'b0, f, rd, ok);
    check(debug_trap === 1'b0, "no trap");
    done("single step");
    ev(5'b00001);
    check(int_take === 1'b0, "masked");
    ev(5'b00010);
    check(nmi_take === 1'b1, "nmi");
    pipe.issue(op_int_set, 4'h0, 1'b0, 2'h0, 64'h0, 1'b0, f, rd, ok);
    check(f === fault_none && flags[9] === 1'b1, "sti");
    ev(5'b00001);
    check(int_take === 1'b1, "maskable taken");
    check(legacy_flags === flags[31:0], "legacy view");
    done("interrupts");
    @(posedge clk);
    #1;
    {status_we, status_value} = {1'b1, 64'hffff_ffff_ffff_ffff};
    @(posedge clk);
    #1;
    status_we = 1'b0;
    pipe.issue(op_flags_read, 4'h0, 1'b0, 2'h3, 64'h0, 1'b0, f, rd, ok);
    check(f === fault_none && (rd & 64'h8d5) === 64'h8d5, "status");
    done("status");
    rstn = 1'b0;
    #1;
    check(feature_control === 64'h0 && flags === 64'h2, "reset regs");
    check(ext_control0 === 64'h1 && page_table_base === 64'h0, "reset ext");
    check(task_priority === 4'h0 && page_size === pg_4k, "reset misc");
    repeat (2) @(posedge clk);
    #1;
    rstn = 1'b1;
    ev(5'b11100);
    check(machine_check_abort === 1'b0 && mc_log === 1'b1, "mc off");
    check(long_mode_ok === 1'b0 && pte_wide === 1'b0, "no long");
    done("reset");
    final_report();
  end
endmodule : testbench
